// File: hdl/asr_exec.sv
/*
  Execution of the accumulator direct and indirect stores, the idle instruction and the
  software reset instruction. Assumes the core decodes the instruction word into op and
  operands, presents them for one cycle with op_valid, and performs the data memory write
  when mem_we pulses.
*/
`timescale 1ns/100ps
module asr_exec (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic                           op_valid,
  input  wire asr_pkg::asr_op_t               op,
  input  wire logic [asr_pkg::FILE_ADDR_W-1:0] file_addr,
  input  wire logic [asr_pkg::BANK_W-1:0]     bank,
  input  wire logic                           ptr_sel,
  input  wire logic [1:0]                     pointer_update_mode,
  input  wire logic [asr_pkg::OFS_W-1:0]      rel_offset,
  input  wire logic [asr_pkg::DATA_W-1:0]     acc,
  input  wire logic [asr_pkg::STATUS_W-1:0]   status_in,
  input  wire logic                           reset_flag_set,
  input  wire logic                           ptr_load,
  input  wire logic                           ptr_load_sel,
  input  wire logic [asr_pkg::PTR_W-1:0]      ptr_load_value,
  output logic                                mem_we,
  output logic [asr_pkg::PTR_W-1:0]           mem_addr,
  output logic [asr_pkg::DATA_W-1:0]          mem_wdata,
  output logic [asr_pkg::STATUS_W-1:0]        status_out,
  output logic                                software_reset_flag,
  output logic                                device_reset_req,
  output logic [asr_pkg::PTR_W-1:0]           indirect_pointer0,
  output logic [asr_pkg::PTR_W-1:0]           indirect_pointer1
);
  import asr_pkg::*;

  typedef struct packed {
    logic                we;
    logic [PTR_W-1:0]    addr;
    logic [DATA_W-1:0]   wdata;
    logic [STATUS_W-1:0] status;
    logic                rst_flag;
    logic                rst_req;
  } asr_exec_state_t;

  asr_exec_state_t st;
  asr_exec_state_t next_st;
  asr_ptr_if       pif ();

  function automatic logic is_window(input logic [FILE_ADDR_W-1:0] a);
    is_window = (a == WINDOW0_ADDR) || (a == WINDOW1_ADDR);
  endfunction : is_window

  wire logic go_direct   = op_valid && (op == ASR_OP_STORE_DIRECT);
  wire logic go_indirect = op_valid && (op == ASR_OP_STORE_INDIRECT);
  wire logic go_rel      = op_valid && (op == ASR_OP_STORE_REL);
  wire logic go_reset    = op_valid && (op == ASR_OP_SW_RESET);

  always_comb begin
    pif.upd        = go_indirect || go_rel;
    pif.rel        = go_rel;
    pif.mode       = pointer_update_mode;
    pif.offset     = rel_offset;
    pif.clear      = go_reset;
    pif.load       = ptr_load;
    pif.load_sel   = ptr_load_sel;
    pif.load_value = ptr_load_value;
    // A window address on a direct store borrows the matching pointer for the lookup.
    if (go_direct && is_window(file_addr)) begin
      pif.sel = (file_addr == WINDOW1_ADDR);
    end else begin
      pif.sel = ptr_sel;
    end
  end

  always_comb begin
    next_st = st;
    next_st.we      = 1'b0;
    next_st.rst_req = 1'b0;
    // Status only mirrors the core; nothing here, pointer steps included, may alter it.
    next_st.status  = status_in;
    if (op_valid) begin
      case (op)
        ASR_OP_STORE_DIRECT: begin
          next_st.we    = 1'b1;
          next_st.wdata = acc;
          if (is_window(file_addr)) begin
            next_st.addr = (file_addr == WINDOW1_ADDR) ? pif.ptr1 : pif.ptr0;
          end else begin
            next_st.addr = {{(PTR_W-BANK_W-FILE_ADDR_W){1'b0}}, bank, file_addr};
          end
        end
        ASR_OP_STORE_INDIRECT, ASR_OP_STORE_REL: begin
          next_st.we    = 1'b1;
          next_st.wdata = acc;
          next_st.addr  = pif.ea;
        end
        ASR_OP_SW_RESET: begin
          next_st.rst_req = 1'b1;
        end
        ASR_OP_IDLE: begin
          next_st.we = 1'b0;
        end
        default: begin
          next_st.we = 1'b0;
        end
      endcase
    end
    // A set request arriving with the software reset still wins.
    if (reset_flag_set) begin
      next_st.rst_flag = 1'b1;
    end else if (go_reset) begin
      next_st.rst_flag = 1'b0;
    end
  end

  // Only the reset flag leaves reset set, so software can tell that no software reset ran
  // since the last hardware reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '{we: 1'b0, addr: PTR_RESET, wdata: '0, status: '0,
              rst_flag: RESET_FLAG_RESET, rst_req: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  asr_ptr_unit u_ptr (
    .clk     (clk),
    .reset_n (reset_n),
    .pif     (pif)
  );

  assign mem_we              = st.we;
  assign mem_addr            = st.addr;
  assign mem_wdata           = st.wdata;
  assign status_out          = st.status;
  assign software_reset_flag = st.rst_flag;
  assign device_reset_req    = st.rst_req;
  assign indirect_pointer0   = pif.ptr0;
  assign indirect_pointer1   = pif.ptr1;

  // Every outcome is registered, so each check looks one cycle after the request was taken; the two pulse checks look two cycles after.
  // A load beside a direct store or an idle is excluded where the check needs the pointers to hold.
  direct_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_direct && !is_window(file_addr)
    |=> mem_we && mem_wdata == $past(acc) && mem_addr == {3'h0, $past(bank), $past(file_addr)})
    else $error("Direct store wrote wrong data or address.");

  window_redirect_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_direct && file_addr == WINDOW1_ADDR |=> mem_we && mem_addr == $past(pif.ptr1))
    else $error("Window store not redirected to pointer.");

  window0_redirect_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_direct && file_addr == WINDOW0_ADDR && !ptr_load
    |=> mem_we && mem_addr == $past(pif.ptr0) && $stable(pif.ptr0))
    else $error("Window store not redirected to pointer zero.");

  direct_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_direct |=> status_out == $past(status_in))
    else $error("Direct store changed status.");

  we_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_direct ##1 !(go_direct || go_indirect || go_rel) |=> !mem_we)
    else $error("Store write pulse lasted more than one cycle.");

  ptr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    ptr_load && !op_valid && !ptr_load_sel |=> indirect_pointer0 == $past(ptr_load_value))
    else $error("Pointer zero did not take the loaded value.");

  pre_inc_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_indirect && pointer_update_mode == MODE_PRE_INC && !ptr_sel
    |=> mem_addr == $past(pif.ptr0) + 16'h0001 && pif.ptr0 == mem_addr)
    else $error("Preincrement store used wrong address.");

  post_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_indirect && pointer_update_mode == MODE_POST_DEC && ptr_sel
    |=> mem_addr == $past(pif.ptr1) && pif.ptr1 == mem_addr - 16'h0001)
    else $error("Postdecrement store used wrong address.");

  pre_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_indirect && pointer_update_mode == MODE_PRE_DEC && ptr_sel
    |=> mem_addr == $past(pif.ptr1) - 16'h0001 && pif.ptr1 == mem_addr)
    else $error("Predecrement store used wrong address.");

  post_inc_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_indirect && pointer_update_mode == MODE_POST_INC && !ptr_sel
    |=> mem_addr == $past(pif.ptr0) && pif.ptr0 == mem_addr + 16'h0001)
    else $error("Postincrement store used wrong address.");

  rel_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_rel |=> mem_we
    && mem_addr == ($past(ptr_sel) ? $past(pif.ptr1) : $past(pif.ptr0))
    + {{10{$past(rel_offset[5])}}, $past(rel_offset)})
    else $error("Relative store used wrong address.");

  status_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_indirect |=> status_out == $past(status_in))
    else $error("Indirect store changed status.");

  sw_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_reset && !reset_flag_set |=> device_reset_req && !software_reset_flag
    && pif.ptr0 == 16'h0000 && pif.ptr1 == 16'h0000)
    else $error("Software reset did not raise the request or clear the flag.");

  sw_reset_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    go_reset ##1 !go_reset |=> !device_reset_req)
    else $error("Software reset request lasted more than one cycle.");

  flag_set_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
    reset_flag_set |=> software_reset_flag)
    else $error("Reset flag set request was lost.");

  idle_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    op_valid && op == ASR_OP_IDLE && !ptr_load |=> !mem_we && $stable(pif.ptr0)
    && $stable(pif.ptr1) && $stable(mem_addr) && $stable(mem_wdata)
    && ($stable(software_reset_flag) || $past(reset_flag_set)))
    else $error("Idle instruction changed state.");
endmodule : asr_exec

// File: hdl/asr_pkg.sv
/*
  Shared constants and types for the accumulator store, idle and software reset execution block.
  Assumes a core that already decoded the instruction word into an operation and its operands.
*/
package asr_pkg;
  localparam int DATA_W      = 8;
  localparam int PTR_W       = 16;
  localparam int FILE_ADDR_W = 7;
  localparam int BANK_W      = 6;
  localparam int OFS_W       = 6;
  localparam int STATUS_W    = 3;

  localparam logic [1:0] MODE_PRE_INC  = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam logic [FILE_ADDR_W-1:0] WINDOW0_ADDR = 7'h00;
  localparam logic [FILE_ADDR_W-1:0] WINDOW1_ADDR = 7'h01;

  localparam logic [PTR_W-1:0] PTR_RESET        = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_STEP_UP      = 16'h0001;
  localparam logic [PTR_W-1:0] PTR_STEP_DOWN    = 16'hffff;
  localparam logic             RESET_FLAG_RESET = 1'b1;

  typedef enum logic [2:0] {
    ASR_OP_IDLE,
    ASR_OP_STORE_DIRECT,
    ASR_OP_STORE_INDIRECT,
    ASR_OP_STORE_REL,
    ASR_OP_SW_RESET
  } asr_op_t;
endpackage : asr_pkg

// File: hdl/asr_ptr_if.sv
/*
  Carrier between the execution top and the indirect pointer unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface asr_ptr_if;
  import asr_pkg::*;
  logic                upd;
  logic                sel;
  logic                rel;
  logic [1:0]          mode;
  logic [OFS_W-1:0]    offset;
  logic                clear;
  logic                load;
  logic                load_sel;
  logic [PTR_W-1:0]    load_value;
  logic [PTR_W-1:0]    ea;
  logic [PTR_W-1:0]    ptr0;
  logic [PTR_W-1:0]    ptr1;

  modport exec (output upd, sel, rel, mode, offset, clear, load, load_sel, load_value,
                input ea, ptr0, ptr1);
  modport unit (input upd, sel, rel, mode, offset, clear, load, load_sel, load_value,
                output ea, ptr0, ptr1);
endinterface : asr_ptr_if

// File: hdl/asr_ptr_unit.sv
/*
  The two 16-bit indirect pointers and their effective address arithmetic.
  Assumes upd and load are single-cycle requests from the execution top.
*/
`timescale 1ns/100ps
module asr_ptr_unit (
  input wire logic clk,
  input wire logic reset_n,
  asr_ptr_if.unit  pif
);
  import asr_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] p0;
    logic [PTR_W-1:0] p1;
  } asr_ptr_state_t;

  asr_ptr_state_t   st;
  asr_ptr_state_t   next_st;
  logic [PTR_W-1:0] cur;
  logic [PTR_W-1:0] step;
  logic [PTR_W-1:0] moved;

  always_comb begin
    cur   = pif.sel ? st.p1 : st.p0;
    step  = pif.mode[0] ? PTR_STEP_DOWN : PTR_STEP_UP;
    // The 16-bit sum drops its carry, which is exactly the wrap at both ends.
    moved = cur + step;
    if (pif.rel) begin
      pif.ea = cur + {{(PTR_W-OFS_W){pif.offset[OFS_W-1]}}, pif.offset};
    end else if (pif.mode[1]) begin
      pif.ea = cur;
    end else begin
      pif.ea = moved;
    end
    next_st = st;
    if (pif.clear) begin
      next_st.p0 = PTR_RESET;
      next_st.p1 = PTR_RESET;
    end else if (pif.upd && !pif.rel) begin
      if (pif.sel) begin
        next_st.p1 = moved;
      end else begin
        next_st.p0 = moved;
      end
    // An indirect or relative store in the same cycle owns the pointers, so a load that collides with it is dropped; one beside a direct store is taken.
    end else if (pif.load && !pif.upd) begin
      if (pif.load_sel) begin
        next_st.p1 = pif.load_value;
      end else begin
        next_st.p0 = pif.load_value;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '{p0: PTR_RESET, p1: PTR_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign pif.ptr0 = st.p0;
  assign pif.ptr1 = st.p1;

  ptr_wrap_up_a: assert property (@(posedge clk) disable iff (!reset_n)
    pif.upd && !pif.rel && !pif.clear && !pif.sel && !pif.mode[0] && st.p0 == 16'hffff
    |=> st.p0 == 16'h0000)
    else $error("Pointer did not wrap from top to zero.");

  ptr_wrap_down_a: assert property (@(posedge clk) disable iff (!reset_n)
    pif.upd && !pif.rel && !pif.clear && pif.sel && pif.mode[0] && st.p1 == 16'h0000
    |=> st.p1 == 16'hffff)
    else $error("Pointer did not wrap from zero to top.");

  rel_ptr_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    pif.upd && pif.rel && !pif.clear |=> $stable(st))
    else $error("Relative store changed a pointer.");
endmodule : asr_ptr_unit

// File: tb/asr_exec_tb.sv
/*
  Self-checking bench for the accumulator store, idle and software reset execution block.
  Assumes asr_exec with its pointer unit inside, one 20 MHz clock and a synchronous reset.
*/
`timescale 1ns/100ps
module asr_exec_tb import asr_pkg::*; ();
  logic                   clk;
  logic                   reset_n;
  logic                   op_valid;
  asr_op_t                op;
  logic [FILE_ADDR_W-1:0] file_addr;
  logic [BANK_W-1:0]      bank;
  logic                   ptr_sel;
  logic [1:0]             pointer_update_mode;
  logic [OFS_W-1:0]       rel_offset;
  logic [DATA_W-1:0]      acc;
  logic [STATUS_W-1:0]    status_in;
  logic                   reset_flag_set;
  logic                   ptr_load;
  logic                   ptr_load_sel;
  logic [PTR_W-1:0]       ptr_load_value;
  logic                   mem_we;
  logic [PTR_W-1:0]       mem_addr;
  logic [DATA_W-1:0]      mem_wdata;
  logic [STATUS_W-1:0]    status_out;
  logic                   software_reset_flag;
  logic                   device_reset_req;
  logic [PTR_W-1:0]       indirect_pointer0;
  logic [PTR_W-1:0]       indirect_pointer1;
  int                     num_errors = 0;
  int                     num_checks = 0;

  asr_exec i_asr_exec (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op(op),
    .file_addr(file_addr), .bank(bank), .ptr_sel(ptr_sel),
    .pointer_update_mode(pointer_update_mode), .rel_offset(rel_offset), .acc(acc),
    .status_in(status_in), .reset_flag_set(reset_flag_set), .ptr_load(ptr_load),
    .ptr_load_sel(ptr_load_sel), .ptr_load_value(ptr_load_value), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .status_out(status_out),
    .software_reset_flag(software_reset_flag), .device_reset_req(device_reset_req),
    .indirect_pointer0(indirect_pointer0), .indirect_pointer1(indirect_pointer1));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] ptr(input logic s);
    return s ? indirect_pointer1 : indirect_pointer0;
  endfunction : ptr

  // One instruction, taken at the next rising edge and judged at the falling edge after it.
  task automatic issue(input asr_op_t o, input logic [6:0] fa, input logic s,
                       input logic [1:0] m, input logic [5:0] k, input logic [7:0] a);
    op_valid = 1'b1;
    op = o;
    file_addr = fa;
    ptr_sel = s;
    pointer_update_mode = m;
    rel_offset = k;
    acc = a;
    status_in = a[2:0] ^ 3'h7;
    @(negedge clk);
    check(status_out, a[2:0] ^ 3'h7);
    check(mem_we, o inside {ASR_OP_STORE_DIRECT, ASR_OP_STORE_INDIRECT, ASR_OP_STORE_REL});
    if (o != ASR_OP_IDLE && o != ASR_OP_SW_RESET) check(mem_wdata, a);
  endtask : issue

  task automatic load_ptr(input logic s, input logic [15:0] v);
    op_valid = 1'b0;
    ptr_load = 1'b1;
    ptr_load_sel = s;
    ptr_load_value = v;
    @(negedge clk);
    ptr_load = 1'b0;
    check(ptr(s), v);
  endtask : load_ptr

  task automatic t_direct;
    bank = 6'h3f;
    issue(ASR_OP_STORE_DIRECT, 7'h7f, 1'b0, 2'h0, 6'h00, 8'ha5);
    check(mem_addr, {3'h0, 6'h3f, 7'h7f});
    issue(ASR_OP_IDLE, 7'h22, 1'b1, 2'h2, 6'h05, 8'h5a);
    check(mem_addr, {3'h0, 6'h3f, 7'h7f});
    check({indirect_pointer0, indirect_pointer1}, 32'h0000_0000);
    check(mem_wdata, 8'ha5);
    $display("test direct and idle done");
  endtask : t_direct

  task automatic t_modes;
    logic [15:0] p;
    logic [15:0] d;
    logic [15:0] e;
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        p = m[0] ? 16'h0000 : 16'hffff;
        d = m[0] ? 16'hffff : 16'h0001;
        e = p + d;
        load_ptr(s[0], p);
        issue(ASR_OP_STORE_INDIRECT, 7'h00, s[0], m[1:0], 6'h00, 8'h40 + m[7:0]);
        check(mem_addr, m[1] ? p : e);
        check(ptr(s[0]), e);
      end
    end
    issue(ASR_OP_STORE_INDIRECT, 7'h00, 1'b1, 2'h2, 6'h00, 8'h11);
    issue(ASR_OP_STORE_INDIRECT, 7'h00, 1'b1, 2'h2, 6'h00, 8'h12);
    check(mem_addr, 16'h0000);
    check(indirect_pointer1, 16'h0001);
    $display("test pointer modes done");
  endtask : t_modes

  task automatic t_rel;
    load_ptr(1'b1, 16'h0010);
    issue(ASR_OP_STORE_REL, 7'h00, 1'b1, 2'h0, 6'h20, 8'h77);
    check(mem_addr, 16'hfff0);
    ptr_load = 1'b1;
    ptr_load_sel = 1'b1;
    ptr_load_value = 16'h5555;
    issue(ASR_OP_STORE_REL, 7'h00, 1'b1, 2'h0, 6'h1f, 8'h78);
    ptr_load = 1'b0;
    check(mem_addr, 16'h002f);
    check(indirect_pointer1, 16'h0010);
    $display("test relative done");
  endtask : t_rel

  task automatic t_window;
    load_ptr(1'b0, 16'h1234);
    load_ptr(1'b1, 16'habcd);
    bank = 6'h05;
    issue(ASR_OP_STORE_DIRECT, 7'h00, 1'b1, 2'h0, 6'h00, 8'h21);
    check(mem_addr, 16'h1234);
    issue(ASR_OP_STORE_DIRECT, 7'h01, 1'b0, 2'h0, 6'h00, 8'h22);
    check(mem_addr, 16'habcd);
    check({indirect_pointer0, indirect_pointer1}, 32'h1234_abcd);
    $display("test window done");
  endtask : t_window

  task automatic t_reset;
    check(software_reset_flag, 1'b1);
    issue(ASR_OP_SW_RESET, 7'h00, 1'b0, 2'h0, 6'h00, 8'h33);
    check(device_reset_req, 1'b1);
    check(software_reset_flag, 1'b0);
    check({indirect_pointer0, indirect_pointer1}, 32'h0000_0000);
    op_valid = 1'b0;
    @(negedge clk);
    check(device_reset_req, 1'b0);
    reset_flag_set = 1'b1;
    issue(ASR_OP_SW_RESET, 7'h00, 1'b0, 2'h0, 6'h00, 8'h34);
    reset_flag_set = 1'b0;
    op_valid = 1'b0;
    check(software_reset_flag, 1'b1);
    $display("test software reset done");
  endtask : t_reset

  // A reset in mid-run must restore every output, the flag too after a software clear.
  task automatic t_hw_reset;
    issue(ASR_OP_SW_RESET, 7'h00, 1'b0, 2'h0, 6'h00, 8'h00);
    check(software_reset_flag, 1'b0);
    load_ptr(1'b1, 16'h0f0f);
    issue(ASR_OP_STORE_INDIRECT, 7'h00, 1'b1, 2'h2, 6'h00, 8'hc3);
    check(mem_addr, 16'h0f0f);
    op_valid = 1'b0;
    reset_n = 1'b0;
    @(negedge clk);
    check({mem_we, device_reset_req, software_reset_flag}, 32'h0000_0001);
    check({mem_addr, mem_wdata, 5'h00, status_out}, 32'h0000_0000);
    check({indirect_pointer0, indirect_pointer1}, 32'h0000_0000);
    reset_n = 1'b1;
    @(negedge clk);
    issue(ASR_OP_STORE_DIRECT, 7'h10, 1'b0, 2'h0, 6'h00, 8'h3c);
    check(mem_addr, 16'h0290);
    op_valid = 1'b0;
    $display("test mid-run reset done");
  endtask : t_hw_reset

  // The run is only a few dozen cycles, so a generous fixed bound catches any hang.
  initial begin
    repeat (400) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    op_valid = 1'b0;
    op = ASR_OP_IDLE;
    file_addr = 7'h00;
    bank = 6'h00;
    ptr_sel = 1'b0;
    pointer_update_mode = 2'h0;
    rel_offset = 6'h00;
    acc = 8'h00;
    status_in = 3'h0;
    reset_flag_set = 1'b0;
    ptr_load = 1'b0;
    ptr_load_sel = 1'b0;
    ptr_load_value = 16'h0000;
    repeat (3) @(negedge clk);
    check({mem_we, device_reset_req, software_reset_flag}, 32'h0000_0001);
    reset_n = 1'b1;
    @(negedge clk);
    t_direct();
    t_modes();
    t_rel();
    t_window();
    t_reset();
    t_hw_reset();
    print_verdict();
  end
endmodule : asr_exec_tb
